// ### logic/sfcd_params.svh
/*
 Shared constants of the serial flash command and address framer: timing counts, address field layout and
 reset values. Assumes the system clock runs at 40 MHz and that it is included by its bare name.
*/
`ifndef SFCD_PARAMS_SVH
`define SFCD_PARAMS_SVH
// System clock rate in Hz.
`define SFCD_SYS_HZ 64'd40000000
// Supply at minimum to first select, least time, in microseconds, and in cycles rounded up.
`define SFCD_SELECT_DELAY_US 64'd70
`define SFCD_SELECT_DELAY_CYC ((`SFCD_SELECT_DELAY_US * `SFCD_SYS_HZ + 64'd999999) / 64'd1000000)
// Power-up to first program or erase, longest time, in milliseconds, and in cycles rounded down.
`define SFCD_WRITE_DELAY_MS 64'd20
`define SFCD_WRITE_DELAY_CYC ((`SFCD_WRITE_DELAY_MS * `SFCD_SYS_HZ) / 64'd1000)
`define SFCD_TIMER_W 20
// Frame lengths in bits.
`define SFCD_BYTE_BITS 7'd8
`define SFCD_ADDR_BITS 7'd24
`define SFCD_CNT_W 7
// Bit positions inside the 24-bit address field.
`define SFCD_PAGE_MSB 21
`define SFCD_PAGE_LSB 10
`define SFCD_BYTE_MSB 9
`define SFCD_BYTE_LSB 0
`define SFCD_PAGE9_LSB 3
`define SFCD_PAGE4_LSB 8
// Don't-care byte counts that follow the address.
`define SFCD_DUMMY_SHORT 3'd1
`define SFCD_DUMMY_LONG 3'd4
// Clock mode after reset: high means mode 3.
`define SFCD_MODE_RESET 1'b1
// Host hold of select after the last bit, and deselect gap, in cycles.
`define SFCD_TAIL_CYC 7'd4
`define SFCD_GAP_CYC 7'd4
`endif

// ### logic/sfcd_pkg.sv
/*
 Types and the opcode decoder shared by both ends of the serial flash command link.
 Assumes sfcd_params.svh is on the include path.
*/
`include "sfcd_params.svh"
package sfcd_pkg;
	// How an opcode uses its address field.
	typedef enum logic [2:0] {sfcd_cls_none, sfcd_cls_full, sfcd_cls_page, sfcd_cls_page9, sfcd_cls_page4,
		sfcd_cls_byte, sfcd_cls_dc, sfcd_cls_unknown} sfcd_cls_t;
	typedef struct packed {
		sfcd_cls_t cls;
		logic has_addr;
		logic [2:0] dummy;
		logic prog;
	} sfcd_dec_t;
	typedef logic [`SFCD_TIMER_W-1:0] sfcd_timer_t;
	typedef logic [`SFCD_CNT_W-1:0] sfcd_cnt_t;

	// Address use, dummy bytes and program or erase class of each opcode.
	function automatic sfcd_dec_t sfcd_decode(input logic [7:0] op);
		sfcd_dec_t d;
		d = '{cls: sfcd_cls_full, has_addr: 1'b1, dummy: 3'd0, prog: 1'b0};
		case (op)
			8'h03, 8'h0b, 8'h82, 8'h85, 8'hd2, 8'he8: d.cls = sfcd_cls_full;
			8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89: d.cls = sfcd_cls_page;
			8'h50: d.cls = sfcd_cls_page9;
			8'h7c: d.cls = sfcd_cls_page4;
			8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6: d.cls = sfcd_cls_byte;
			8'h77: d.cls = sfcd_cls_dc;
			8'h9f, 8'hb9, 8'hab, 8'hd7: d.cls = sfcd_cls_none;
			default: d.cls = sfcd_cls_unknown;
		endcase
		case (op)
			8'h0b, 8'hd4, 8'hd6: d.dummy = `SFCD_DUMMY_SHORT;
			8'hd2, 8'he8: d.dummy = `SFCD_DUMMY_LONG;
			default: d.dummy = 3'd0;
		endcase
		case (op)
			8'h50, 8'h58, 8'h59, 8'h7c, 8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h88, 8'h89: d.prog = 1'b1;
			default: d.prog = 1'b0;
		endcase
		// Unknown opcodes carry no address so the frame ends after the opcode byte.
		d.has_addr = !(d.cls == sfcd_cls_none || d.cls == sfcd_cls_unknown);
		return d;
	endfunction : sfcd_decode

	// Total bits of opcode, address and don't-care bytes in one frame.
	function automatic sfcd_cnt_t sfcd_frame_bits(input sfcd_dec_t d);
		sfcd_cnt_t n;
		n = `SFCD_BYTE_BITS + (d.has_addr ? `SFCD_ADDR_BITS : 7'd0) + {1'b0, d.dummy, 3'b000};
		return n;
	endfunction : sfcd_frame_bits
endpackage : sfcd_pkg

// ### logic/sfcd_link_if.sv
/*
 The four-wire serial link between the flash end and the host end.
 Assumes the bench resolves the data-out wire from so and so_oe.
*/
`timescale 1ns/1ps
interface sfcd_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	modport dev (input cs_n, input sck, input si, output so, output so_oe);
	modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface : sfcd_link_if

// ### logic/sfcd_dev.sv
/*
 Flash end of the command link: shifts in opcode, address and don't-care bytes on the serial clock,
 hands each finished command to the system clock domain, masks the address by opcode and tracks
 clock mode, power-up state and the write hold-off. Assumes the host leads each frame with select low
 and the clock at its idle level, and keeps select low at least three system cycles past the last bit.
*/
`timescale 1ns/1ps
// How it works
// (R1) Address field: 2 spare, 12 page, 10 byte.
// (R2) Page and byte bits split; spare bits ignored.
// (R3) Full-address opcodes yield page and byte.
// (R4) Page-only opcodes drop byte bits.
// (R5) Block opcode keeps page bits eleven to three.
// (R6) Sector opcode keeps page bits eleven to eight.
// (R7) Buffer-only opcodes drop page bits.
// (R8) Opcode 77h all don't care; four opcodes addressless.
// (R9) One or four don't-care bytes follow some addresses.
// (R10) Reset gives mode 3, output released.
// (R11) Decode only after a select falling edge.
// (R12) Each select fall samples idle clock for mode.
// (R13) Held in reset, commands are ignored.
// (R14) Host waits 70 us before first select.
// (R15) No program or erase before 20 ms.
// (R16) Power-up ends in standby.
// (R17) Most significant bit first, select low throughout.
module sfcd_dev
	import sfcd_pkg::*;
#(
	parameter sfcd_timer_t WRITE_DELAY_CYC = sfcd_timer_t'(`SFCD_WRITE_DELAY_CYC)
)
(
	// System side
	input wire logic clk_sys,
	input wire logic reset,
	// Link
	sfcd_link_if.dev link,
	// Decoded command
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [11:0] cmd_page,
	output logic [9:0] cmd_byte,
	output logic cmd_known,
	output logic cmd_refused,
	// Status
	output logic clk_mode3,
	output logic dev_standby,
	output logic write_allowed
);
	typedef enum logic {sfcd_dev_por, sfcd_dev_standby} sfcd_dev_st_t;

	// Link-domain framing state, cleared whenever select is high.
	typedef struct packed {
		sfcd_cnt_t cnt;
		logic [23:0] sh;
		logic [7:0] op;
		logic [23:0] addr;
		logic done;
	} sfcd_lk_t;

	// Finished command word, held until the next frame completes.
	typedef struct packed {
		logic [7:0] op;
		logic [23:0] addr;
	} sfcd_word_t;

	// System-domain state.
	typedef struct packed {
		sfcd_dev_st_t st;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic sk_s1;
		logic sk_s2;
		logic dn_s1;
		logic dn_s2;
		logic dn_s3;
		logic armed;
		logic mode3;
		sfcd_timer_t tmr;
		logic wr_ok;
		logic cmd_valid;
		logic [7:0] cmd_opcode;
		logic [11:0] cmd_page;
		logic [9:0] cmd_byte;
		logic cmd_known;
		logic cmd_refused;
	} sfcd_sys_t;

	sfcd_lk_t lk;
	sfcd_lk_t next_lk;
	sfcd_word_t word;
	sfcd_word_t next_word;
	sfcd_sys_t r;
	sfcd_sys_t next_r;

	// The flash end never drives data out here; the pin stays released.
	assign link.so = 1'b0;
	assign link.so_oe = 1'b0; // R10

	// Bit shifter on the link clock; each bit lands on the rising edge, which serves modes 0 and 3 alike.
	always_comb
	begin
		logic [7:0] op_now;
		logic [23:0] addr_now;
		sfcd_cnt_t cnt_inc;
		sfcd_dec_t dec;
		op_now = (lk.cnt == 7'd7) ? {lk.sh[6:0], link.si} : lk.op;
		addr_now = (lk.cnt == 7'd31) ? {lk.sh[22:0], link.si} : lk.addr;
		cnt_inc = lk.cnt + 7'd1;
		dec = sfcd_decode(op_now);
		next_lk = lk;
		next_word = word;
		if (!lk.done)
		begin
			next_lk.sh = {lk.sh[22:0], link.si}; // R17
			next_lk.cnt = cnt_inc;
			if (lk.cnt == 7'd7)
				next_lk.op = op_now;
			if (lk.cnt == 7'd31)
				next_lk.addr = addr_now; // R1
			// The frame ends after opcode, address and any don't-care bytes; later bits are data.
			if (cnt_inc == sfcd_frame_bits(dec)) // R8 R9
			begin
				next_lk.done = 1'b1;
				next_word.op = op_now;
				next_word.addr = dec.has_addr ? addr_now : 24'h000000;
			end
		end
	end

	// Select high clears the framer, so a frame always starts from bit zero without any link clock edge.
	always_ff @(posedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
			lk <= '{cnt: '0, sh: '0, op: '0, addr: '0, done: 1'b0}; // R17
		else
			lk <= next_lk;
	end

	// The word is only read after done has crossed, so it needs no reset.
	always_ff @(posedge link.sck)
	begin
		word <= next_word;
	end

	// System domain: synchronisers, power-up sequencing, mode capture and command hand-off.
	always_comb
	begin
		logic cs_fall;
		logic dn_rise;
		sfcd_dec_t dec;
		logic [11:0] page;
		logic [9:0] bsel;
		cs_fall = r.cs_s3 & ~r.cs_s2;
		dn_rise = r.dn_s2 & ~r.dn_s3;
		dec = sfcd_decode(word.op);
		page = word.addr[`SFCD_PAGE_MSB:`SFCD_PAGE_LSB]; // R2
		bsel = word.addr[`SFCD_BYTE_MSB:`SFCD_BYTE_LSB]; // R2
		next_r = r;
		next_r.cmd_valid = 1'b0;
		next_r.cmd_refused = 1'b0;
		next_r.cs_s1 = link.cs_n;
		next_r.cs_s2 = r.cs_s1;
		next_r.cs_s3 = r.cs_s2;
		next_r.sk_s1 = link.sck;
		next_r.sk_s2 = r.sk_s1;
		next_r.dn_s1 = lk.done;
		next_r.dn_s2 = r.dn_s1;
		next_r.dn_s3 = r.dn_s2;
		case (r.st)
			sfcd_dev_por:
				next_r.st = sfcd_dev_standby; // R16
			sfcd_dev_standby:
			begin
				// The timer saturates, so write permission never lapses once given.
				if (r.tmr != WRITE_DELAY_CYC)
					next_r.tmr = r.tmr + 1'b1;
				else
					next_r.wr_ok = 1'b1; // R15
				if (cs_fall)
				begin
					next_r.armed = 1'b1; // R11
					next_r.mode3 = r.sk_s2; // R12
				end
				if (dn_rise && r.armed) // R11
				begin
					next_r.cmd_opcode = word.op;
					next_r.cmd_known = (dec.cls != sfcd_cls_unknown);
					case (dec.cls)
						sfcd_cls_full:
						begin
							next_r.cmd_page = page; // R3
							next_r.cmd_byte = bsel; // R3
						end
						sfcd_cls_page:
						begin
							next_r.cmd_page = page; // R4
							next_r.cmd_byte = 10'h000; // R4
						end
						sfcd_cls_page9:
						begin
							next_r.cmd_page = (page >> `SFCD_PAGE9_LSB) << `SFCD_PAGE9_LSB; // R5
							next_r.cmd_byte = 10'h000; // R5
						end
						sfcd_cls_page4:
						begin
							next_r.cmd_page = (page >> `SFCD_PAGE4_LSB) << `SFCD_PAGE4_LSB; // R6
							next_r.cmd_byte = 10'h000; // R6
						end
						sfcd_cls_byte:
						begin
							next_r.cmd_page = 12'h000; // R7
							next_r.cmd_byte = bsel; // R7
						end
						default:
						begin
							next_r.cmd_page = 12'h000; // R8
							next_r.cmd_byte = 10'h000; // R8
						end
					endcase
					// A program or erase before the hold-off ends is reported and not passed on.
					if (dec.prog && !r.wr_ok)
						next_r.cmd_refused = 1'b1; // R15
					else
						next_r.cmd_valid = 1'b1;
				end
			end
			default:
				next_r.st = sfcd_dev_por;
		endcase
		// Select sync resets low so a select already low at release is not taken for a fresh edge.
		if (reset)
		begin
			next_r = '0; // R13
			next_r.st = sfcd_dev_por;
			next_r.mode3 = `SFCD_MODE_RESET; // R10
		end
	end

	always_ff @(posedge clk_sys)
	begin
		r <= next_r;
	end

	assign cmd_valid = r.cmd_valid;
	assign cmd_opcode = r.cmd_opcode;
	assign cmd_page = r.cmd_page;
	assign cmd_byte = r.cmd_byte;
	assign cmd_known = r.cmd_known;
	assign cmd_refused = r.cmd_refused;
	assign clk_mode3 = r.mode3;
	assign dev_standby = (r.st == sfcd_dev_standby);
	assign write_allowed = r.wr_ok;
endmodule : sfcd_dev

// ### logic/sfcd_host.sv
/*
 Host end of the command link: after the power-up wait, frames one opcode with its address and
 don't-care bytes, driving select and a divided serial clock. Assumes the flash end samples on the
 rising clock edge and that requests come from logic on clk_sys.
*/
`timescale 1ns/1ps
module sfcd_host
	import sfcd_pkg::*;
#(
	parameter sfcd_timer_t WRITE_DELAY_CYC = sfcd_timer_t'(`SFCD_WRITE_DELAY_CYC)
)
(
	// System side
	input wire logic clk_sys,
	input wire logic reset,
	// Link
	sfcd_link_if.host link,
	// Command request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_opcode,
	input wire logic [11:0] req_page,
	input wire logic [9:0] req_byte,
	input wire logic req_mode3,
	// Status
	output logic xfer_done,
	output logic select_ready,
	output logic write_ready
);
	typedef enum logic [2:0] {sfcd_h_boot, sfcd_h_idle, sfcd_h_pre, sfcd_h_lead, sfcd_h_low, sfcd_h_high,
		sfcd_h_tail, sfcd_h_gap} sfcd_h_st_t;

	typedef struct packed {
		sfcd_h_st_t st;
		sfcd_timer_t tmr;
		logic sel_ok;
		logic wr_ok;
		sfcd_cnt_t cnt;
		sfcd_cnt_t tot;
		logic [63:0] sh;
		logic idle_hi;
		logic cs_n;
		logic sck;
		logic done;
	} sfcd_host_t;

	localparam sfcd_timer_t SELECT_DELAY_CYC = sfcd_timer_t'(`SFCD_SELECT_DELAY_CYC);

	sfcd_host_t r;
	sfcd_host_t next_r;
	sfcd_dec_t req_dec;

	// Writes are held back until the flash may program or erase.
	assign req_dec = sfcd_decode(req_opcode);
	assign req_ready = (r.st == sfcd_h_idle) && (!req_dec.prog || r.wr_ok); // R15

	// Each bit takes two system cycles, so the serial clock is half the system clock.
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		// One timer serves both waits, so it runs until the longer of the two has passed.
		if (r.tmr < WRITE_DELAY_CYC || r.tmr < SELECT_DELAY_CYC)
			next_r.tmr = r.tmr + 1'b1;
		if (r.tmr >= WRITE_DELAY_CYC)
			next_r.wr_ok = 1'b1; // R15
		if (r.tmr >= SELECT_DELAY_CYC)
			next_r.sel_ok = 1'b1; // R14
		case (r.st)
			sfcd_h_boot:
				if (r.sel_ok)
					next_r.st = sfcd_h_idle; // R14
			sfcd_h_idle:
				if (req_valid && req_ready)
				begin
					// Spare bits go out as zero; don't-care bytes are zero too.
					next_r.sh = {req_opcode, 2'b00, req_page, req_byte, 32'h00000000}; // R1 R9
					next_r.tot = sfcd_frame_bits(req_dec); // R9
					next_r.cnt = '0;
					next_r.idle_hi = req_mode3;
					next_r.sck = req_mode3;
					next_r.st = sfcd_h_pre;
				end
			// Select falls one cycle after the clock reaches its idle level, so no clock edge meets the select edge.
			sfcd_h_pre:
			begin
				next_r.cs_n = 1'b0; // R11 R12
				next_r.st = sfcd_h_lead;
			end
			sfcd_h_lead:
			begin
				next_r.sck = 1'b0;
				next_r.st = sfcd_h_low;
			end
			sfcd_h_low:
			begin
				next_r.sck = 1'b1;
				next_r.st = sfcd_h_high;
			end
			sfcd_h_high:
			begin
				next_r.sh = {r.sh[62:0], 1'b0}; // R17
				next_r.cnt = r.cnt + 7'd1;
				if (r.cnt + 7'd1 == r.tot)
				begin
					next_r.sck = r.idle_hi;
					next_r.cnt = '0;
					next_r.st = sfcd_h_tail;
				end
				else
				begin
					next_r.sck = 1'b0;
					next_r.st = sfcd_h_low;
				end
			end
			// Select stays low a few cycles so the flash end sees the frame finish.
			sfcd_h_tail:
			begin
				next_r.cnt = r.cnt + 7'd1;
				if (r.cnt == `SFCD_TAIL_CYC - 7'd1)
				begin
					next_r.cs_n = 1'b1; // R17
					next_r.cnt = '0;
					next_r.st = sfcd_h_gap;
				end
			end
			sfcd_h_gap:
			begin
				next_r.cnt = r.cnt + 7'd1;
				if (r.cnt == `SFCD_GAP_CYC - 7'd1)
				begin
					next_r.done = 1'b1;
					next_r.st = sfcd_h_idle;
				end
			end
			default:
				next_r.st = sfcd_h_boot;
		endcase
		if (reset)
		begin
			next_r = '0;
			next_r.st = sfcd_h_boot;
			next_r.cs_n = 1'b1; // R11
		end
	end

	always_ff @(posedge clk_sys)
	begin
		r <= next_r;
	end

	assign link.cs_n = r.cs_n;
	assign link.sck = r.sck;
	assign link.si = r.sh[63]; // R17
	assign xfer_done = r.done;
	assign select_ready = r.sel_ok;
	assign write_ready = r.wr_ok;
endmodule : sfcd_host

// ### test/sfcd_link_asserts.sv
/*
 Checker of the four link wires between the host end and the flash end.
 Assumes the testbench instantiates it beside the interface and that the host drives the link on clk_sys.
*/
`timescale 1ns/1ps
module sfcd_link_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Link wires
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic sck_q;
	logic cs_q;
	logic [6:0] nbit;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Count rising clock edges in a frame; gating on the old select keeps the mode 3 lead edge out.
	always_ff @(posedge clk_sys)
	begin
		sck_q <= sck;
		cs_q <= cs_n;
		if (reset || cs_n)
			nbit <= 7'h00;
		else if (sck && !sck_q && !cs_q)
			nbit <= nbit + 7'h01;
	end
	chk_so_released: assert property (so_oe == 1'b0 && so == 1'b0)
		else $error("flash output pin driven");
	chk_cs_reset: assert property (disable iff (1'b0) reset |=> cs_n)
		else $error("select low during reset");
	chk_idle_sck: assert property ($fell(cs_n) |-> $stable(sck))
		else $error("select fell while the serial clock moved");
	chk_lead_edge: assert property ($fell(cs_n) |=> !$rose(sck))
		else $error("clock edge too soon after select fall");
	chk_si_rise: assert property (!cs_n && !$past(cs_n) && $rose(sck) |-> $stable(si))
		else $error("data changed on a sampling edge");
	chk_gap_len: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("deselect gap too short");
	chk_tail_len: assert property ($rose(cs_n) |-> $past(cs_n, 4) == 1'b0)
		else $error("select released too soon");
	chk_frame_bits: assert property ($rose(cs_n) |-> nbit inside {7'd8, 7'd32, 7'd40, 7'd64})
		else $error("frame bit count wrong");
	cov_mode3: cover property ($fell(cs_n) && sck);
	cov_long: cover property ($rose(cs_n) && nbit == 7'd64);
	cov_short: cover property ($rose(cs_n) && nbit == 7'd8);
endmodule : sfcd_link_chk

// ### test/serial_flash_cmd_addr_decode_test.sv
/*
 Testbench: host end and flash end joined by one link, plus a second flash end that the bench drives
 with a 12 ns clock to break host rules. Assumes the design files are compiled first.
*/
`timescale 1ns/1ps
module serial_flash_cmd_addr_decode_test
	import sfcd_pkg::*;
;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	logic req_mode3 = 1'b0;
	logic [7:0] req_opcode = 8'h00;
	logic [11:0] req_page = 12'h000;
	logic [9:0] req_byte = 10'h000;
	logic rdy, xd, sel_rdy, wr_rdy;
	logic cv[2], cr[2], ck[2], cm[2], sb[2], wa[2];
	logic [7:0] co[2];
	logic [11:0] cp[2];
	logic [9:0] cb[2];
	int nv[2], nr[2];
	int cyc_cnt, mismatches, compares;
	logic [7:0] ops[31] = '{8'h03, 8'h0b, 8'h82, 8'h85, 8'hd2, 8'he8, 8'h53, 8'h55, 8'h58, 8'h59, 8'h60,
		8'h61, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89, 8'h50, 8'h7c, 8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6,
		8'h77, 8'h9f, 8'hb9, 8'hab, 8'hd7, 8'h00};
	sfcd_link_if link();
	sfcd_link_if link2();
	sfcd_dev #(.WRITE_DELAY_CYC(20'h000c8)) i_sfcd_dev (.clk_sys(clk_sys), .reset(reset), .link(link.dev),
		.cmd_valid(cv[0]), .cmd_opcode(co[0]), .cmd_page(cp[0]), .cmd_byte(cb[0]), .cmd_known(ck[0]),
		.cmd_refused(cr[0]), .clk_mode3(cm[0]), .dev_standby(sb[0]), .write_allowed(wa[0]));
	sfcd_dev #(.WRITE_DELAY_CYC(20'h000c8)) i_sfcd_dev_b (.clk_sys(clk_sys), .reset(reset), .link(link2.dev),
		.cmd_valid(cv[1]), .cmd_opcode(co[1]), .cmd_page(cp[1]), .cmd_byte(cb[1]), .cmd_known(ck[1]),
		.cmd_refused(cr[1]), .clk_mode3(cm[1]), .dev_standby(sb[1]), .write_allowed(wa[1]));
	sfcd_host #(.WRITE_DELAY_CYC(20'h000c8)) i_sfcd_host (.clk_sys(clk_sys), .reset(reset), .link(link.host),
		.req_valid(req_valid), .req_ready(rdy), .req_opcode(req_opcode), .req_page(req_page),
		.req_byte(req_byte), .req_mode3(req_mode3), .xfer_done(xd), .select_ready(sel_rdy), .write_ready(wr_rdy));
	sfcd_link_chk i_sfcd_link_chk (.clk_sys(clk_sys), .reset(reset), .cs_n(link.cs_n), .sck(link.sck),
		.si(link.si), .so(link.so), .so_oe(link.so_oe));
	// The system clock, 25 ns.
	always #12.5 clk_sys = ~clk_sys;
	// Pulses are counted so that a missing or doubled one shows.
	always @(posedge clk_sys)
	begin
		cyc_cnt += !reset;
		for (int i = 0; i < 2; i++)
		begin
			nv[i] += (cv[i] === 1'b1);
			nr[i] += (cr[i] === 1'b1);
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic summarize;
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : cyc
	// Expected decode; the page and byte pattern is lopsided so a slipped mask shows.
	function automatic void ex(input logic [7:0] o, output logic k, output logic [11:0] p,
		output logic [9:0] b, output int n);
		{k, p, b, n} = {1'b1, 12'ha5c, 10'h3a6, 32'd32};
		case (o)
			8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89: b = 10'h000;
			8'h50: {p, b} = {12'ha58, 10'h000};
			8'h7c: {p, b} = {12'ha00, 10'h000};
			8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6: p = 12'h000;
			8'h77: {p, b} = 22'h000000;
			8'h9f, 8'hb9, 8'hab, 8'hd7: {p, b, n} = {22'h000000, 32'd8};
			8'h00: {k, p, b, n} = {1'b0, 22'h000000, 32'd8};
			default: ;
		endcase
		case (o)
			8'h0b, 8'hd4, 8'hd6: n = n + 8;
			8'hd2, 8'he8: n = n + 32;
			default: ;
		endcase
	endfunction : ex
	// Frame sent by hand to the second flash end; the clock stands still outside the bits.
	task automatic send2(input logic [31:0] w, input int n, input logic idle);
		link2.sck = idle;
		cyc(4);
		link2.cs_n = 1'b0;
		cyc(3);
		for (int i = 31; i > 31 - n; i--)
		begin
			link2.sck = 1'b0;
			link2.si = w[i];
			#6 link2.sck = 1'b1;
			#6;
		end
		link2.sck = idle;
		link2.si = ~link2.si;
		cyc(5);
		link2.cs_n = 1'b1;
		cyc(6);
	endtask : send2
	task automatic t_dev_boot;
		int n;
		cyc(2);
		chk("standby", sb[1], 1'b1);
		chk("reset_mode", cm[1], 1'b1);
		chk("so_oe", link2.so_oe, 1'b0);
		chk("early_write", wa[1], 1'b0);
		send2({8'h03, 24'h000000}, 32, 1'b0);
		chk("no_fall", nv[1] + nr[1], 0);
		send2({8'h58, 24'h3fffff}, 32, 1'b0);
		chk("refused", nr[1], 1);
		chk("refused_op", co[1], 8'h58);
		chk("mode0", cm[1], 1'b0);
		send2({8'h03, 24'h000000}, 20, 1'b0);
		chk("cut_short", nv[1] + nr[1], 1);
		n = 0;
		while (wa[1] !== 1'b1 && n < 400)
		begin
			cyc(1);
			n++;
		end
		chk("write_allowed", wa[1], 1'b1);
		send2({8'h03, 2'b11, 12'ha5c, 10'h3a6}, 32, 1'b1);
		chk("valid", nv[1], 1);
		chk("spare_page", cp[1], 12'ha5c);
		chk("spare_byte", cb[1], 10'h3a6);
		chk("mode3", cm[1], 1'b1);
	endtask : t_dev_boot
	task automatic t_host_boot;
		int n;
		chk("sel_early", sel_rdy, 1'b0);
		chk("req_early", rdy, 1'b0);
		n = 0;
		while (sel_rdy !== 1'b1 && n < 4000)
		begin
			cyc(1);
			n++;
		end
		chk("sel_delay", cyc_cnt >= 2800, 1'b1);
		chk("wr_ready", wr_rdy, 1'b1);
		chk("standby0", sb[0], 1'b1);
		chk("write0", wa[0], 1'b1);
	endtask : t_host_boot
	// Every listed opcode and one unlisted, through both ends, alternating clock mode.
	task automatic t_host_ops;
		logic k;
		logic [11:0] p;
		logic [9:0] b;
		int n, bits, c0;
		for (int i = 0; i < 31; i++)
		begin
			ex(ops[i], k, p, b, bits);
			c0 = nv[0];
			n = 0;
			while (rdy !== 1'b1 && n < 400)
			begin
				cyc(1);
				n++;
			end
			{req_opcode, req_page, req_byte, req_mode3, req_valid} = {ops[i], 12'ha5c, 10'h3a6, i[0], 1'b1};
			cyc(1);
			req_valid = 1'b0;
			n = 0;
			while (xd !== 1'b1 && n < 300)
			begin
				cyc(1);
				n++;
			end
			chk("frame_len", n, 2 * bits + 10);
			chk("pulse", nv[0] - c0, 1);
			chk("opcode", co[0], ops[i]);
			chk("known", ck[0], k);
			chk("page", cp[0], p);
			chk("byte", cb[0], b);
			chk("mode", cm[0], i[0]);
		end
		chk("no_refuse", nr[0], 0);
	endtask : t_host_ops
	// Main sequence.
	initial
	begin
		link2.cs_n = 1'b0;
		link2.sck = 1'b0;
		link2.si = 1'b0;
		repeat (2) @(posedge clk_sys);
		#2 reset = 1'b0;
		t_dev_boot();
		t_host_boot();
		t_host_ops();
		summarize();
	end
	// Watchdog, about four times the expected run.
	initial
	begin
		#500000;
		mismatches++;
		summarize();
	end
endmodule : serial_flash_cmd_addr_decode_test
